// ===== rtl/idio_map.vh
`ifndef IDIO_MAP_VH
`define IDIO_MAP_VH

`define IDIO_CLK_HZ            200000000
`define IDIO_MAX_RATE_HZ       10000
`define IDIO_MIN_DIV           (`IDIO_CLK_HZ / `IDIO_MAX_RATE_HZ)
`define IDIO_RST_DIV           32'h0000_4E20

`define IDIO_ADDR_CTRL         4'h0
`define IDIO_ADDR_STATUS       4'h1
`define IDIO_ADDR_DIVIDER      4'h2
`define IDIO_ADDR_OUT          4'h3
`define IDIO_ADDR_PORT         4'h4

`define IDIO_CTRL_RUN_BIT      0
`define IDIO_ST_ENABLED_BIT    0
`define IDIO_ST_OPEN_DRAIN_BIT 1
`define IDIO_ST_RANGE_24V_BIT  2
`define IDIO_ST_NEW_SAMPLE_BIT 3

`define IDIO_RST_OUT           8'h00
`define IDIO_PRE_READ_OUT      8'hFF

`endif

// ===== rtl/idio_sampler.v
`timescale 1ns/1ps
`include "idio_map.vh"

module idio_sampler #(
  parameter WIDTH = 8
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             run,
  input  wire [31:0]      divider,
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] sample,
  output reg              tick
);

  reg [31:0]      count;
  reg [WIDTH-1:0] sticky;
  wire [31:0]     limit;
  wire            fire;

  // Dividers below the fastest allowed rate are raised to it.
  assign limit = (divider < `IDIO_MIN_DIV) ? `IDIO_MIN_DIV : divider;
  assign fire  = run && (count >= limit - 32'h0000_0001);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count  <= 32'h0000_0000;
      sticky <= {WIDTH{1'b0}};
      sample <= {WIDTH{1'b0}};
      tick   <= 1'b0;
    end else begin
      tick <= fire;
      if (!run || fire) begin
        count <= 32'h0000_0000;
      end else begin
        count <= count + 32'h0000_0001;
      end
      if (fire) begin
        // A high level seen in the tick cycle seeds the next interval.
        sample <= sticky | din;
        sticky <= din;
      end else begin
        sticky <= sticky | din;
      end
    end
  end

endmodule

// ===== rtl/idio_port.v
`timescale 1ns/1ps
`include "idio_map.vh"

module idio_port #(
  parameter WIDTH = 8
) (
  input  wire             CLK_SYS,
  input  wire             RSTN,
  input  wire [3:0]       AVS_ADDRESS,
  input  wire             AVS_READ,
  input  wire             AVS_WRITE,
  input  wire [31:0]      AVS_WRITEDATA,
  input  wire [3:0]       AVS_BYTEENABLE,
  output reg  [31:0]      AVS_READDATA,
  output reg              AVS_WAITREQUEST,
  input  wire [WIDTH-1:0] DIN,
  input  wire             LEVEL_SEL_N,
  input  wire             DRIVER_TYPE_SELECT_PIN,
  output reg  [WIDTH-1:0] HIGH_SIDE_ON,
  output reg  [WIDTH-1:0] LOW_SIDE_ON,
  output reg  [WIDTH-1:0] DOUT,
  output reg  [WIDTH-1:0] DOUT_OE_N,
  output reg              RANGE_24V,
  output reg              SAMPLE_TICK
);

  // Output modes of the whole driver group.
  localparam MODE_OFF   = 2'b00;
  localparam MODE_TOTEM = 2'b01;
  localparam MODE_OPEN  = 2'b10;

  reg  [WIDTH-1:0] din_meta;
  reg  [WIDTH-1:0] din_sync;
  reg  [1:0]       lvl_sync;
  reg  [1:0]       drv_sync;
  reg              run;
  reg  [31:0]      divider;
  reg  [WIDTH-1:0] out_word;
  reg  [1:0]       mode;
  reg  [1:0]       next_mode;
  reg              new_sample;
  reg  [15:0]      port_word;
  reg  [31:0]      next_readdata;
  reg  [WIDTH-1:0] next_high;
  reg  [WIDTH-1:0] next_low;
  reg  [WIDTH-1:0] next_dout;
  reg  [WIDTH-1:0] next_oe_n;
  wire [WIDTH-1:0] sample;
  wire             tick;
  wire             enabled;
  wire             open_drain;
  wire             access;
  wire             wr;
  wire             rd;
  wire             wr_ctrl;
  wire             wr_divider;
  wire             wr_out;
  wire             rd_port;

  function [31:0] idio_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  be;
    integer i;
    begin
      idio_merge = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          idio_merge[i*8 +: 8] = new_val[i*8 +: 8];
        end
      end
    end
  endfunction

  function idio_hit;
    input [3:0] addr;
    input [3:0] index;
    begin
      idio_hit = (addr == index);
    end
  endfunction

  assign access     = (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  assign wr         = AVS_WRITE && AVS_WAITREQUEST;
  assign rd         = AVS_READ && AVS_WAITREQUEST;
  assign wr_ctrl    = wr && idio_hit(AVS_ADDRESS, `IDIO_ADDR_CTRL) && AVS_BYTEENABLE[0];
  assign wr_divider = wr && idio_hit(AVS_ADDRESS, `IDIO_ADDR_DIVIDER);
  assign wr_out     = wr && idio_hit(AVS_ADDRESS, `IDIO_ADDR_OUT) && AVS_BYTEENABLE[0];
  assign rd_port    = rd && idio_hit(AVS_ADDRESS, `IDIO_ADDR_PORT);
  assign enabled    = (mode != MODE_OFF);
  assign open_drain = (mode == MODE_OPEN);

  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      din_meta <= {WIDTH{1'b0}};
      din_sync <= {WIDTH{1'b0}};
    end else begin
      din_meta <= DIN;
      din_sync <= din_meta;
    end
  end

  // An open level pin selects the 24 V range, so the synchroniser resets to that level.
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      lvl_sync <= 2'b11;
    end else begin
      lvl_sync <= {lvl_sync[0], LEVEL_SEL_N};
    end
  end

  // An unsettled driver-type pin reads as open-drain, which never sources current.
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      drv_sync <= 2'b11;
    end else begin
      drv_sync <= {drv_sync[0], DRIVER_TYPE_SELECT_PIN};
    end
  end

  idio_sampler #(
    .WIDTH (WIDTH)
  ) u_sampler (
    .clk     (CLK_SYS),
    .rst_n   (RSTN),
    .run     (run),
    .divider (divider),
    .din     (din_sync),
    .sample  (sample),
    .tick    (tick)
  );

  always @* begin
    next_readdata = 32'h0000_0000;
    case (AVS_ADDRESS)
      `IDIO_ADDR_CTRL: begin
        next_readdata[`IDIO_CTRL_RUN_BIT] = run;
      end
      `IDIO_ADDR_STATUS: begin
        next_readdata[`IDIO_ST_ENABLED_BIT]    = enabled;
        next_readdata[`IDIO_ST_OPEN_DRAIN_BIT] = open_drain;
        next_readdata[`IDIO_ST_RANGE_24V_BIT]  = lvl_sync[1];
        next_readdata[`IDIO_ST_NEW_SAMPLE_BIT] = new_sample;
      end
      `IDIO_ADDR_DIVIDER: begin
        next_readdata = divider;
      end
      `IDIO_ADDR_OUT: begin
        next_readdata[WIDTH-1:0] = enabled ? out_word : `IDIO_PRE_READ_OUT;
      end
      `IDIO_ADDR_PORT: begin
        next_readdata[15:0] = port_word;
      end
      default: begin
        next_readdata = 32'h0000_0000;
      end
    endcase
  end

  // Every access gets one wait cycle, then waitrequest is low for exactly one cycle.
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h0000_0000;
    end else begin
      AVS_WAITREQUEST <= !access;
      if (rd) begin
        AVS_READDATA <= next_readdata;
      end
    end
  end

  // The divider honours every byte lane; the run flag lives in lane 0.
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      run     <= 1'b0;
      divider <= `IDIO_RST_DIV;
    end else begin
      if (wr_ctrl) begin
        run <= AVS_WRITEDATA[`IDIO_CTRL_RUN_BIT];
      end
      if (wr_divider) begin
        divider <= idio_merge(divider, AVS_WRITEDATA, AVS_BYTEENABLE);
      end
    end
  end

  // The driver type is taken from the pin only when the outputs first switch on.
  always @* begin
    next_mode = mode;
    case (mode)
      MODE_OFF: begin
        if (wr_out) begin
          next_mode = drv_sync[1] ? MODE_OPEN : MODE_TOTEM;
        end
      end
      MODE_TOTEM: begin
        next_mode = MODE_TOTEM;
      end
      MODE_OPEN: begin
        next_mode = MODE_OPEN;
      end
      default: begin
        next_mode = MODE_OFF;
      end
    endcase
  end

  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      out_word <= `IDIO_RST_OUT;
      mode     <= MODE_OFF;
    end else begin
      mode <= next_mode;
      if (wr_out) begin
        out_word <= AVS_WRITEDATA[WIDTH-1:0];
      end
    end
  end

  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      RANGE_24V   <= 1'b1;
      SAMPLE_TICK <= 1'b0;
    end else begin
      RANGE_24V   <= lvl_sync[1];
      SAMPLE_TICK <= tick;
    end
  end

  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      new_sample <= 1'b0;
      port_word  <= 16'h0000;
    end else begin
      if (tick) begin
        port_word <= {{(16-WIDTH){1'b0}}, sample};
      end
      // A new sample wins over a read of the port word in the same cycle.
      if (tick) begin
        new_sample <= 1'b1;
      end else if (rd_port) begin
        new_sample <= 1'b0;
      end
    end
  end

  always @* begin
    next_high = {WIDTH{1'b0}};
    next_low  = {WIDTH{1'b0}};
    next_dout = {WIDTH{1'b0}};
    next_oe_n = {WIDTH{1'b1}};
    case (mode)
      MODE_TOTEM: begin
        // Outputs first switch on with the written word, so a 0 never shows high.
        next_high = out_word;
        next_low  = ~out_word;
        next_dout = out_word;
        next_oe_n = {WIDTH{1'b0}};
      end
      MODE_OPEN: begin
        next_low  = ~out_word;
        next_oe_n = out_word;
      end
      default: begin
        next_oe_n = {WIDTH{1'b1}};
      end
    endcase
  end

  // Switch commands are registered so that no decode glitch reaches a driver.
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      HIGH_SIDE_ON <= {WIDTH{1'b0}};
      LOW_SIDE_ON  <= {WIDTH{1'b0}};
      DOUT         <= {WIDTH{1'b0}};
      DOUT_OE_N    <= {WIDTH{1'b1}};
    end else begin
      HIGH_SIDE_ON <= next_high;
      LOW_SIDE_ON  <= next_low;
      DOUT         <= next_dout;
      DOUT_OE_N    <= next_oe_n;
    end
  end

endmodule

// ===== sim/idio_port_chk.sv
`timescale 1ns/1ps
`include "idio_map.vh"
module idio_port_chk #(
  parameter WIDTH = 8
) (
  input wire             CLK_SYS,
  input wire             RSTN,
  input wire [3:0]       AVS_ADDRESS,
  input wire             AVS_READ,
  input wire             AVS_WRITE,
  input wire             AVS_WAITREQUEST,
  input wire             LEVEL_SEL_N,
  input wire [WIDTH-1:0] HIGH_SIDE_ON,
  input wire [WIDTH-1:0] LOW_SIDE_ON,
  input wire [WIDTH-1:0] DOUT,
  input wire [WIDTH-1:0] DOUT_OE_N,
  input wire             RANGE_24V,
  input wire             SAMPLE_TICK
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  a_bus_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=>
    !AVS_WAITREQUEST) else $error("access not answered");
  a_bus_pulse: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("answer too long");
  a_idle_off: assert property (&DOUT_OE_N |-> !(|HIGH_SIDE_ON))
    else $error("high switch on while released");
  a_high_side: assert property (HIGH_SIDE_ON == (DOUT & ~DOUT_OE_N))
    else $error("high switch wrong");
  a_low_side: assert property (LOW_SIDE_ON == ~(DOUT | DOUT_OE_N))
    else $error("low switch wrong");
  a_out_cause: assert property ($changed(DOUT_OE_N) || $changed(DOUT) |->
    $past(AVS_WRITE && AVS_ADDRESS == `IDIO_ADDR_OUT, 2)) else $error("output moved alone");
  a_tick_pulse: assert property (SAMPLE_TICK |=> !SAMPLE_TICK [*8])
    else $error("ticks too close");
  a_range_follow: assert property ($stable(LEVEL_SEL_N) [*5] |->
    RANGE_24V == LEVEL_SEL_N) else $error("range wrong");
  cover property (SAMPLE_TICK);
  cover property ($fell(&DOUT_OE_N));
  cover property (AVS_WRITE && !AVS_WAITREQUEST);
endmodule

// ===== sim/idio_field.sv
`timescale 1ns/1ps
module idio_field (
  input  wire       clk,
  input  wire       fire,
  input  wire [7:0] mask,
  input  wire [7:0] dout,
  input  wire [7:0] oe_n,
  output reg  [7:0] din = 8'h00,
  output wire [7:0] pin
);
  // Inputs rest at the pull-down level; a fired pulse lasts one clock.
  always @(posedge clk) begin
    din <= fire ? mask : 8'h00;
  end
  assign pin = dout | oe_n;
endmodule

// ===== sim/testbench.sv
`timescale 1ns/1ps
`include "idio_map.vh"
module testbench;
  reg         clk = 1'h0;
  reg         rstn = 1'h0;
  reg  [3:0]  addr = 4'h0;
  reg         rd = 1'h0;
  reg         wr = 1'h0;
  reg  [31:0] wdata = 32'h0000_0000;
  reg         lvl = 1'h1;
  reg         drv = 1'h0;
  reg         fire = 1'h0;
  reg  [31:0] got;
  integer     num_errors = 0;
  integer     n_tests = 0;
  wire [31:0] rdata;
  wire [7:0]  din, hi, lo, dout, oe_n, pin;
  wire        wreq, rng, tick;
  initial forever #2.5 clk = ~clk;
  idio_port i_idio_port (.CLK_SYS(clk), .RSTN(rstn), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wreq), .DIN(din), .LEVEL_SEL_N(lvl), .DRIVER_TYPE_SELECT_PIN(drv),
    .HIGH_SIDE_ON(hi), .LOW_SIDE_ON(lo), .DOUT(dout), .DOUT_OE_N(oe_n), .RANGE_24V(rng),
    .SAMPLE_TICK(tick));
  idio_field i_idio_field (.clk(clk), .fire(fire), .mask(8'h81), .dout(dout), .oe_n(oe_n),
    .din(din), .pin(pin));
  task report_and_stop;
    begin
      if (num_errors == 0 && n_tests > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("unexpected at %0t: %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task bus(input w, input [3:0] a, input [31:0] d);
    integer i;
    begin
      @(posedge clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      i = 0;
      do begin
        @(posedge clk);
        i = i + 1;
      end while (wreq !== 1'h0 && i < 50);
      got = rdata;
      wr <= 1'h0;
      rd <= 1'h0;
      if (i >= 50) begin
        num_errors = num_errors + 1;
        report_and_stop;
      end
    end
  endtask
  task wait_tick;
    integer i;
    begin
      i = 0;
      do begin
        @(posedge clk);
        i = i + 1;
      end while (tick !== 1'h1 && i < 25000);
      if (i >= 25000) begin
        num_errors = num_errors + 1;
        report_and_stop;
      end
    end
  endtask
  task sc_idle;
    begin
      chk(oe_n, 8'hFF);
      chk({hi, lo}, 16'h0000);
      bus(1'h0, `IDIO_ADDR_OUT, 0);
      chk(got, 32'h0000_00FF);
      chk(rng, 1'h1);
      lvl <= 1'h0;
      repeat (5) @(posedge clk);
      chk(rng, 1'h0);
      lvl <= 1'h1;
      bus(1'h0, 4'hF, 0);
      chk(got, 32'h0000_0000);
    end
  endtask
  task sc_pulse;
    begin
      bus(1'h1, `IDIO_ADDR_DIVIDER, 32'h0000_0001);
      bus(1'h1, `IDIO_ADDR_CTRL, 32'h0000_0001);
      fire <= 1'h1;
      @(posedge clk);
      fire <= 1'h0;
      wait_tick;
      bus(1'h0, `IDIO_ADDR_PORT, 0);
      chk(got, 32'h0000_0081);
      wait_tick;
      bus(1'h0, `IDIO_ADDR_PORT, 0);
      chk(got, 32'h0000_0000);
    end
  endtask
  task sc_totem;
    begin
      bus(1'h1, `IDIO_ADDR_OUT, 0);
      repeat (2) @(posedge clk);
      chk({oe_n, hi, lo}, 24'h00_00FF);
      bus(1'h0, `IDIO_ADDR_STATUS, 0);
      chk(got, 32'h0000_0005);
      drv <= 1'h1;
      bus(1'h1, `IDIO_ADDR_OUT, 32'h0000_00A5);
      repeat (2) @(posedge clk);
      chk({oe_n, hi, lo, pin}, 32'h00A5_5AA5);
    end
  endtask
  task sc_od;
    begin
      rstn <= 1'h0;
      repeat (2) @(posedge clk);
      rstn <= 1'h1;
      bus(1'h1, `IDIO_ADDR_OUT, 32'h0000_000F);
      repeat (2) @(posedge clk);
      chk({oe_n, hi, lo, pin}, 32'h0F00_F00F);
      bus(1'h0, `IDIO_ADDR_STATUS, 0);
      chk(got, 32'h0000_0007);
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'h1;
    sc_idle;
    sc_pulse;
    sc_totem;
    sc_od;
    report_and_stop;
  end
endmodule
bind idio_port idio_port_chk #(.WIDTH(WIDTH)) i_idio_port_chk (.CLK_SYS(CLK_SYS),
  .RSTN(RSTN), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .LEVEL_SEL_N(LEVEL_SEL_N), .HIGH_SIDE_ON(HIGH_SIDE_ON),
  .LOW_SIDE_ON(LOW_SIDE_ON), .DOUT(DOUT), .DOUT_OE_N(DOUT_OE_N), .RANGE_24V(RANGE_24V),
  .SAMPLE_TICK(SAMPLE_TICK));
